/* File: common/status_enc_pkg.sv */
`default_nettype none
package status_enc_pkg;
  // basic status codes
  localparam logic [1:0] BST_INIT    = 2'h0;
  localparam logic [1:0] BST_NORMAL  = 2'h1;
  localparam logic [1:0] BST_SELFTST = 2'h2;
  localparam logic [1:0] BST_ERROR   = 2'h3;
  // detailed status codes
  localparam logic [1:0] DST_NONE    = 2'h0;
  localparam logic [1:0] DST_MEMORY  = 2'h1;
  localparam logic [1:0] DST_SUPPLY  = 2'h2;
  localparam logic [1:0] DST_SERIAL  = 2'h3;
  // source-id echo forced under a freezing fault
  localparam logic [2:0] ECHO_ZERO   = 3'h0;
  localparam logic [3:0] SELFTEST_OFF = 4'h0;
  // sensor data field selection
  typedef enum logic [2:0] {
    DATA_LIVE  = 3'b001,
    DATA_ZERO  = 3'b010,
    DATA_ECODE = 3'b100
  } data_sel_t;
  // fault source index; lower index = higher priority
  localparam int NSRC       = 7;
  localparam int SRC_SERIAL = 0;
  localparam int SRC_RESET  = 1;
  localparam int SRC_SUPPLY = 2;
  localparam int SRC_TEST   = 3;
  localparam int SRC_FOTP   = 4;
  localparam int SRC_URW    = 5;
  localparam int SRC_UOTP   = 6;
endpackage : status_enc_pkg
`default_nettype wire

/* File: rtl/fault_prio_pick.sv */
`default_nettype none
module fault_prio_pick
  import status_enc_pkg::*;
#(
  parameter int N = NSRC
) (
  input  wire logic [N-1:0] req_in,
  output logic      [N-1:0] grant_out,
  output logic              any_out
);
  // ----------------------------------------
  // lowest index wins
  // ----------------------------------------
  logic [N:0] blocked;
  assign blocked[0] = 1'b0;
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pick
      assign grant_out[i] = req_in[i] & ~blocked[i];
      assign blocked[i+1] = blocked[i] | req_in[i];
    end
  endgenerate
  assign any_out = blocked[N];
endmodule : fault_prio_pick
`default_nettype wire

/* File: rtl/spi_response_status_encoder.sv */
`default_nettype none
module spi_response_status_encoder
  import status_enc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       cs_release_in,
  input  wire logic       alt_status_sel_in,
  input  wire logic       init_complete_flag_in,
  input  wire logic [3:0] selftest_control_in,
  input  wire logic       test_mode_flag_in,
  input  wire logic       user_fuse_bank0_in,
  input  wire logic       user_fuse_bank1_in,
  input  wire logic       user_fuse_bank2_in,
  input  wire logic       factory_otp_err_in,
  input  wire logic       supply_fault_in,
  input  wire logic       supply_fault_hold_off_in,
  input  wire logic       supply_timer_expired_in,
  input  wire logic       reset_occurred_flag_in,
  input  wire logic       serial_cmd_err_in,
  output logic [1:0]      basic_status_field_out,
  output logic [1:0]      detailed_status_field_out,
  output logic [2:0]      data_sel_out,
  output logic            echo_zero_out,
  output logic            reg_err_resp_out,
  output logic            arm_freeze_out,
  output logic            aux_ctrl_disable_out,
  output logic            alt_scheme_out
);
  // ----------------------------------------
  // source gathering and priority
  // ----------------------------------------
  logic [NSRC-1:0] req;
  logic [NSRC-1:0] grant;
  logic            any_err;
  always_comb begin
    req             = '0;
    req[SRC_SERIAL] = serial_cmd_err_in;
    req[SRC_RESET]  = reset_occurred_flag_in;
    req[SRC_SUPPLY] = supply_fault_in;
    req[SRC_TEST]   = test_mode_flag_in;
    req[SRC_FOTP]   = factory_otp_err_in;
    req[SRC_URW]    = user_fuse_bank2_in;
    req[SRC_UOTP]   = user_fuse_bank0_in | user_fuse_bank1_in;
  end

  fault_prio_pick #(.N(NSRC)) u_pick (
    .req_in    (req),
    .grant_out (grant),
    .any_out   (any_err)
  );

  // ----------------------------------------
  // next status
  // ----------------------------------------
  logic [1:0] bst_d, bst_q, dst_d, dst_q;
  data_sel_t  sel_d, sel_q;
  logic       echo_d, echo_q, rerr_d, rerr_q, frz_d, frz_q;
  logic       aux_d, aux_q, alt_d, alt_q;
  always_comb begin
    bst_d  = bst_q;
    dst_d  = dst_q;
    sel_d  = sel_q;
    echo_d = echo_q;
    rerr_d = rerr_q;
    frz_d  = frz_q;
    aux_d  = aux_q;
    alt_d  = alt_q;
    if (cs_release_in) begin
      alt_d  = alt_status_sel_in;
      sel_d  = DATA_LIVE;
      dst_d  = DST_NONE;
      echo_d = 1'b0;
      rerr_d = 1'b0;
      frz_d  = 1'b0;
      aux_d  = 1'b0;
      if (any_err) begin
        bst_d  = BST_ERROR;
        echo_d = 1'b1;
        frz_d  = 1'b1;
        sel_d  = DATA_ECODE;
      end else if (selftest_control_in != SELFTEST_OFF) begin
        bst_d = BST_SELFTST;
      end else if (!init_complete_flag_in) begin
        bst_d = BST_INIT;
      end else begin
        bst_d = BST_NORMAL;
      end
      if (grant[SRC_SERIAL]) begin
        dst_d  = DST_SERIAL;
        rerr_d = 1'b1;
      end else if (grant[SRC_RESET]) begin
        dst_d = DST_SUPPLY;
      end else if (grant[SRC_SUPPLY]) begin
        dst_d = DST_SUPPLY;
        aux_d = !supply_fault_hold_off_in;
        if (!supply_timer_expired_in || supply_fault_hold_off_in) begin
          sel_d = DATA_ZERO;
        end
      end else if (grant[SRC_TEST]) begin
        dst_d = DST_MEMORY;
        sel_d = DATA_ZERO;
      end else if (any_err) begin
        dst_d = DST_MEMORY;
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bst_q  <= BST_INIT;
      dst_q  <= DST_NONE;
      sel_q  <= DATA_LIVE;
      echo_q <= 1'b0;
      rerr_q <= 1'b0;
      frz_q  <= 1'b0;
      aux_q  <= 1'b0;
      alt_q  <= 1'b0;
    end else begin
      bst_q  <= bst_d;
      dst_q  <= dst_d;
      sel_q  <= sel_d;
      echo_q <= echo_d;
      rerr_q <= rerr_d;
      frz_q  <= frz_d;
      aux_q  <= aux_d;
      alt_q  <= alt_d;
    end
  end

  assign basic_status_field_out    = bst_q;
  assign detailed_status_field_out = dst_q;
  assign data_sel_out              = sel_q;
  assign echo_zero_out             = echo_q;
  assign reg_err_resp_out          = rerr_q;
  assign arm_freeze_out            = frz_q;
  assign aux_ctrl_disable_out      = aux_q;
  assign alt_scheme_out            = alt_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_hold;
    @(posedge clk_in) disable iff (sys_rst_in)
      !cs_release_in |=> $stable(bst_q) && $stable(dst_q);
  endproperty
  a_hold: assert property (p_hold) else $error("status changed without release");

  property p_serial;
    @(posedge clk_in) disable iff (sys_rst_in)
      cs_release_in && serial_cmd_err_in |=>
        bst_q == BST_ERROR && dst_q == DST_SERIAL && rerr_q && echo_q && frz_q;
  endproperty
  a_serial: assert property (p_serial) else $error("serial error mis-encoded");

  property p_reset;
    @(posedge clk_in) disable iff (sys_rst_in)
      cs_release_in && !serial_cmd_err_in && reset_occurred_flag_in |=>
        dst_q == DST_SUPPLY && sel_q == DATA_ECODE && !rerr_q;
  endproperty
  a_reset: assert property (p_reset) else $error("reset record mis-encoded");

  property p_supply_zero;
    @(posedge clk_in) disable iff (sys_rst_in)
      cs_release_in && req[2:0] == 3'h4 && !supply_timer_expired_in |=>
        sel_q == DATA_ZERO && dst_q == DST_SUPPLY;
  endproperty
  a_supply_zero: assert property (p_supply_zero) else $error("supply zeros missing");

  property p_holdoff;
    @(posedge clk_in) disable iff (sys_rst_in)
      cs_release_in && req[2:0] == 3'h4 && supply_fault_hold_off_in |=>
        sel_q == DATA_ZERO && !aux_q && frz_q;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("hold-off supply mis-encoded");

  property p_test;
    @(posedge clk_in) disable iff (sys_rst_in)
      cs_release_in && req[3:0] == 4'h8 |=> dst_q == DST_MEMORY && sel_q == DATA_ZERO;
  endproperty
  a_test: assert property (p_test) else $error("test mode mis-encoded");

  property p_fotp;
    @(posedge clk_in) disable iff (sys_rst_in)
      cs_release_in && req[4:0] == 5'h10 |=> dst_q == DST_MEMORY && sel_q == DATA_ECODE;
  endproperty
  a_fotp: assert property (p_fotp) else $error("factory fault mis-encoded");

  property p_urw;
    @(posedge clk_in) disable iff (sys_rst_in)
      cs_release_in && req[5:0] == 6'h20 |=> dst_q == DST_MEMORY && echo_q && frz_q;
  endproperty
  a_urw: assert property (p_urw) else $error("user rw fault mis-encoded");

  property p_uotp;
    @(posedge clk_in) disable iff (sys_rst_in)
      cs_release_in && req == 7'h40 |=> dst_q == DST_MEMORY && !rerr_q && frz_q;
  endproperty
  a_uotp: assert property (p_uotp) else $error("user fuse fault mis-encoded");

  property p_clean;
    @(posedge clk_in) disable iff (sys_rst_in)
      cs_release_in && !any_err |=> dst_q == DST_NONE && sel_q == DATA_LIVE && bst_q != BST_ERROR;
  endproperty
  a_clean: assert property (p_clean) else $error("clean status mis-encoded");

  property p_alt;
    @(posedge clk_in) disable iff (sys_rst_in)
      cs_release_in |=> alt_q == $past(alt_status_sel_in);
  endproperty
  a_alt: assert property (p_alt) else $error("alt select not captured");

  property p_group;
    @(posedge clk_in) disable iff (sys_rst_in)
      bst_q != BST_ERROR |-> dst_q == DST_NONE;
  endproperty
  a_group: assert property (p_group) else $error("group without error");

  property p_prio;
    @(posedge clk_in) disable iff (sys_rst_in)
      cs_release_in && serial_cmd_err_in && supply_fault_in |=> dst_q == DST_SERIAL;
  endproperty
  a_prio: assert property (p_prio) else $error("priority wrong");

  c_err:  cover property (@(posedge clk_in) cs_release_in && any_err);
  c_st:   cover property (@(posedge clk_in) bst_q == BST_SELFTST);
  c_zero: cover property (@(posedge clk_in) sel_q == DATA_ZERO);
endmodule : spi_response_status_encoder
`default_nettype wire

/* File: tb/spi_master_model.sv */
`default_nettype none
module spi_master_model (
  input  wire logic clk_in,
  output logic      cs_release_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cs_release_out = 1'b0;
  // one-cycle release at end of frame
  task automatic pulse();
    @(negedge clk_in);
    cs_release_out = 1'b1;
    @(negedge clk_in);
    cs_release_out = 1'b0;
  endtask : pulse
endmodule : spi_master_model
`default_nettype wire

/* File: tb/test_spi_response_status_encoder.sv */
`default_nettype none
module test_spi_response_status_encoder;
  import status_enc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, cs;
  logic [11:0] f;
  logic [3:0] st;
  logic [1:0] bo, dox;
  logic [2:0] so;
  logic eo, ro, ao, xo, lo;
  int n_mismatch = 0;
  int checks = 0;
  int i;
  spi_master_model m (.clk_in(clk), .cs_release_out(cs));
  spi_response_status_encoder dut (
    .clk_in(clk), .sys_rst_in(rst), .cs_release_in(cs), .alt_status_sel_in(f[11]),
    .init_complete_flag_in(f[10]), .selftest_control_in(st), .test_mode_flag_in(f[3]),
    .user_fuse_bank0_in(f[6]), .user_fuse_bank1_in(f[7]), .user_fuse_bank2_in(f[5]),
    .factory_otp_err_in(f[4]), .supply_fault_in(f[2]), .supply_fault_hold_off_in(f[8]),
    .supply_timer_expired_in(f[9]), .reset_occurred_flag_in(f[1]),
    .serial_cmd_err_in(f[0]), .basic_status_field_out(bo), .detailed_status_field_out(dox),
    .data_sel_out(so), .echo_zero_out(eo), .reg_err_resp_out(ro), .arm_freeze_out(ao),
    .aux_ctrl_disable_out(xo), .alt_scheme_out(lo));
  // -------------------------------------------
  // expectation
  // -------------------------------------------
  function automatic logic [11:0] expect_of(input logic [11:0] v, input logic [3:0] s);
    logic [1:0] b, d;
    logic [2:0] ds;
    logic e, r, x;
    b = (s != SELFTEST_OFF) ? BST_SELFTST : (v[10] ? BST_NORMAL : BST_INIT);
    d = DST_NONE;
    ds = DATA_LIVE;
    {e, r, x} = 3'h0;
    if (|v[7:0]) begin
      b = BST_ERROR;
      e = 1'b1;
      ds = DATA_ECODE;
      d = DST_MEMORY;
      if (v[0]) begin
        d = DST_SERIAL;
        r = 1'b1;
      end else if (v[1]) begin
        d = DST_SUPPLY;
      end else if (v[2]) begin
        d = DST_SUPPLY;
        x = !v[8];
        ds = (!v[8] && v[9]) ? DATA_ECODE : DATA_ZERO;
      end else if (v[3]) begin
        ds = DATA_ZERO;
      end
    end
    return {b, d, ds, e, r, e, x, v[11]};
  endfunction : expect_of
  // -------------------------------------------
  // stimulus and checks
  // -------------------------------------------
  task automatic check(input logic [11:0] e);
    logic [11:0] k, o;
    k = (f[2] && |f[1:0]) ? 12'hFFD : 12'hFFF;
    o = {bo, dox, so, eo, ro, ao, xo, lo};
    checks++;
    if ((o & k) !== (e & k)) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, o & k, e & k);
    end
  endtask : check
  task automatic run(input logic [11:0] v, input logic [3:0] s);
    logic [11:0] e;
    e = expect_of(v, s);
    f = v;
    st = s;
    m.pulse();
    check(e);
    f = ~v;
    st = ~s;
    @(negedge clk);
    check(e);
  endtask : run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    f = 12'h000;
    st = 4'h0;
    void'($urandom(41));
    repeat (3) @(negedge clk);
    rst = 1'b0;
    check(12'h020);
    $display("reset test done");
    for (i = 0; i < 8; i++) run(12'h400 | (12'h001 << i), 4'h0);
    for (i = 0; i < 4; i++) run(12'h004 | (i << 8), 4'h0);
    for (i = 0; i < 4; i++) run({i[1:0], 10'h000}, i[3:0] << 1);
    run(12'hFFF, 4'hF);
    run(12'hCF8, 4'h3);
    $display("corner test done");
    for (i = 0; i < 300; i++) begin
      run($urandom & $urandom & $urandom, ($urandom % 4 == 0) ? 4'($urandom) : 4'h0);
    end
    $display("random test done");
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    check(12'h020);
    rst = 1'b0;
    run(12'h001, 4'h0);
    $display("second reset test done");
    report_and_stop();
  end
endmodule : test_spi_response_status_encoder
`default_nettype wire
